// ---- include/rpo_pkg.sv ----
// constants, field layout and helpers for the remappable output pin select block
package rpo_pkg;

   // geometry of the block
   localparam int RPO_NUM_PINS = 12;
   localparam int RPO_FIRST_PIN = 20;
   localparam int RPO_NUM_MAPS = 6;
   localparam int RPO_SEL_W = 6;
   localparam int RPO_DATA_W = 16;
   localparam int RPO_ADDR_W = 4;
   localparam int RPO_FUNC_W = 64;

   // index of pin 31 within the remappable group (pin 20 is index 0)
   localparam int RPO_PIN31_IDX = 11;

   // register offsets (word index on the register port)
   localparam logic [3:0] RPO_OFF_MAP_20_21 = 4'h0;
   localparam logic [3:0] RPO_OFF_MAP_22_23 = 4'h1;
   localparam logic [3:0] RPO_OFF_MAP_24_25 = 4'h2;
   localparam logic [3:0] RPO_OFF_MAP_26_27 = 4'h3;
   localparam logic [3:0] RPO_OFF_MAP_28_29 = 4'h4;
   localparam logic [3:0] RPO_OFF_MAP_30_31 = 4'h5;
   localparam logic [3:0] RPO_OFF_ROUTE_STAT = 4'h6;
   localparam logic [3:0] RPO_OFF_BAD_SEL = 4'h7;
   localparam logic [3:0] RPO_OFF_PAD_LEVEL = 4'h8;

   // field positions inside a mapping register
   localparam int RPO_ODD_LSB = 8;
   localparam int RPO_ODD_MSB = 13;
   localparam int RPO_EVEN_LSB = 0;
   localparam int RPO_EVEN_MSB = 5;

   // reset values
   localparam logic [15:0] RPO_MAP_RST = 16'h0000;
   localparam logic [5:0] RPO_SEL_RST = 6'h00;
   localparam logic [11:0] RPO_PIN_RST = 12'h000;

   // selector codes: zero routes nothing; above the last defined code routes nothing
   localparam logic [5:0] RPO_SEL_NONE = 6'h00;
   localparam logic [5:0] RPO_FUNC_LAST = 6'h1F;

   // true when a selector names a defined peripheral output
   function automatic logic rpo_sel_defined(input logic [5:0] sel);
      rpo_sel_defined = (sel != RPO_SEL_NONE) && (sel <= RPO_FUNC_LAST);
   endfunction : rpo_sel_defined

   // build a readback word from two fields; gaps read as zero
   function automatic logic [15:0] rpo_pack_map(input logic [5:0] odd_sel,
                                                input logic [5:0] even_sel);
      rpo_pack_map = {2'b00, odd_sel, 2'b00, even_sel};
   endfunction : rpo_pack_map

endpackage : rpo_pkg

// ---- include/rpo_sel_if.sv ----
// carrier between the register side and the output routing matrix
`timescale 1ns/1ns
interface rpo_sel_if;
   import rpo_pkg::*;

   // selector per pin, index 0 is pin 20
   logic [RPO_NUM_PINS-1:0][RPO_SEL_W-1:0] sel;
   // all peripheral outputs, bit n is function number n
   logic [RPO_FUNC_W-1:0] func_out;
   // routed level and "a peripheral owns this pin" per pin
   logic [RPO_NUM_PINS-1:0] route_d;
   logic [RPO_NUM_PINS-1:0] route_en;

   modport ctl (output sel, output func_out, input route_d, input route_en);
   modport mux (input sel, input func_out, output route_d, output route_en);
endinterface : rpo_sel_if

// ---- src/rpo_out_mux.sv ----
// routing matrix: picks one peripheral output per remappable pin
`timescale 1ns/1ns
module rpo_out_mux
   import rpo_pkg::*;
(
   rpo_sel_if.mux sel_bus
);

   // one 64:1 pick per pin; undefined codes leave the pin to its port
   always_comb begin
      for (int p = 0; p < RPO_NUM_PINS; p++) begin
         sel_bus.route_en[p] = rpo_sel_defined(sel_bus.sel[p]);
         if (sel_bus.route_en[p]) begin
            sel_bus.route_d[p] = sel_bus.func_out[sel_bus.sel[p]];
         end else begin
            sel_bus.route_d[p] = 1'b0;
         end
      end
   end

endmodule : rpo_out_mux

// ---- src/rpo_pin_map.sv ----
// output pin select for remappable pins 20 to 31: registers, routing and pad drive
//
// What this block does
// - Each remappable pin whose selector holds a defined code (1 to 31) is driven by the peripheral output of that number.
// - The selector of the odd pin of each pair (21..31) lives in bits 13 to 8 of its register.
// - The selector of the even pin of each pair (20..30) lives in bits 5 to 0 of its register.
// - Bits 15 and 14 of each mapping register are not stored and read as zero.
// - Bits 7 and 6 of each mapping register are not stored and read as zero.
// - Reset clears every stored selector bit of all six mapping registers.
// - Software can write every selector bit and reads back the last value written.
// - On reduced pin count parts the pin 31 selector is absent, reads zero and routes nothing.
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ns
module rpo_pin_map
   import rpo_pkg::*;
#(
   // 1 = full pin count part with pin 31; 0 = reduced part without it
   parameter bit FULL_PIN_COUNT = 1'b1
)(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [RPO_ADDR_W-1:0] reg_addr,
   input wire logic [RPO_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [RPO_DATA_W-1:0] reg_rdata,
   input wire logic [RPO_FUNC_W-1:0] periph_out,
   input wire logic [RPO_NUM_PINS-1:0] port_out,
   input wire logic [RPO_NUM_PINS-1:0] port_oe,
   output logic [RPO_NUM_PINS-1:0] remap_pin_out,
   output logic [RPO_NUM_PINS-1:0] remap_pin_oe
);

   // selector storage, index 0 is pin 20, index 11 is pin 31
   logic [RPO_NUM_PINS-1:0][RPO_SEL_W-1:0] sel_q;

   // registered status seen by software
   logic [RPO_NUM_PINS-1:0] route_q;
   logic [RPO_NUM_PINS-1:0] bad_sel_q;

   // pad drive
   logic [RPO_NUM_PINS-1:0] pad_out_q;
   logic [RPO_NUM_PINS-1:0] pad_oe_q;

   // read path
   logic [RPO_DATA_W-1:0] rdata_d;
   logic [RPO_DATA_W-1:0] rdata_q;

   // which mapping register a write hits
   logic map_wr_hit;
   logic [2:0] map_idx;

   // pin 31 is present only on the full pin count part
   logic pin31_present;

   rpo_sel_if sel_bus ();

   assign pin31_present = FULL_PIN_COUNT;

   // flag a bus offset that falls on one of the six mapping registers
   function automatic logic map_offset_hit(input logic [3:0] addr);
      // the block starts at offset zero, so only the upper end needs a compare
      map_offset_hit = (addr <= RPO_OFF_MAP_30_31);
   endfunction : map_offset_hit

   // selector as stored; pin 31 is forced out on the reduced part
   function automatic logic [5:0] stored_sel(input int pin, input logic [5:0] val,
                                             input logic has31);
      if ((pin == RPO_PIN31_IDX) && !has31) begin
         stored_sel = RPO_SEL_RST;
      end else begin
         stored_sel = val;
      end
   endfunction : stored_sel

   // write decode; offsets of the six mapping registers are contiguous
   always_comb begin
      map_wr_hit = reg_wr && map_offset_hit(reg_addr);
      map_idx = 3'(reg_addr - RPO_OFF_MAP_20_21);
   end

   // selector registers; only the implemented bits are stored at all,
   // so the unimplemented gaps cannot hold a stale one
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sel_q <= '{default: RPO_SEL_RST};
      end else if (map_wr_hit) begin
         for (int m = 0; m < RPO_NUM_MAPS; m++) begin
            if (map_idx == 3'(m)) begin
               // even pin of the pair from the low field
               sel_q[2*m] <= stored_sel(2*m,
                  reg_wdata[RPO_EVEN_MSB:RPO_EVEN_LSB], pin31_present);
               // odd pin of the pair from the high field
               sel_q[2*m+1] <= stored_sel(2*m+1,
                  reg_wdata[RPO_ODD_MSB:RPO_ODD_LSB], pin31_present);
            end
         end
      end
   end

   // feed the routing matrix; a missing pin 31 sees a zero selector and routes nothing
   always_comb begin
      for (int p = 0; p < RPO_NUM_PINS; p++) begin
         sel_bus.sel[p] = stored_sel(p, sel_q[p], pin31_present);
      end
      sel_bus.func_out = periph_out;
   end

   rpo_out_mux u_mux (
      .sel_bus (sel_bus.mux)
   );

   // status capture: which pins a peripheral owns, and which hold an
   // undefined nonzero code (written but routing nothing)
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         route_q <= RPO_PIN_RST;
         bad_sel_q <= RPO_PIN_RST;
      end else begin
         route_q <= sel_bus.route_en;
         for (int p = 0; p < RPO_NUM_PINS; p++) begin
            bad_sel_q[p] <= (sel_bus.sel[p] != RPO_SEL_NONE) && !sel_bus.route_en[p];
         end
      end
   end

   // pad drive; registered so the pad never sees selector decode glitches,
   // at the cost of one cycle from selector or peripheral change to pin
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pad_out_q <= RPO_PIN_RST;
         pad_oe_q <= RPO_PIN_RST;
      end else begin
         for (int p = 0; p < RPO_NUM_PINS; p++) begin
            if (sel_bus.route_en[p]) begin
               pad_out_q[p] <= sel_bus.route_d[p];
               pad_oe_q[p] <= 1'b1;
            end else begin
               pad_out_q[p] <= port_out[p];
               pad_oe_q[p] <= port_oe[p];
            end
         end
      end
   end

   assign remap_pin_out = pad_out_q;
   assign remap_pin_oe = pad_oe_q;

   // read mux; gaps in the mapping words and unmapped offsets read zero
   always_comb begin
      rdata_d = RPO_MAP_RST;
      if (map_offset_hit(reg_addr)) begin
         for (int m = 0; m < RPO_NUM_MAPS; m++) begin
            if (3'(reg_addr - RPO_OFF_MAP_20_21) == 3'(m)) begin
               rdata_d = rpo_pack_map(sel_bus.sel[2*m+1], sel_bus.sel[2*m]);
            end
         end
      end else if (reg_addr == RPO_OFF_ROUTE_STAT) begin
         rdata_d = {4'h0, route_q};
      end else if (reg_addr == RPO_OFF_BAD_SEL) begin
         rdata_d = {4'h0, bad_sel_q};
      end else if (reg_addr == RPO_OFF_PAD_LEVEL) begin
         rdata_d = {4'h0, pad_out_q};
      end
   end

   // read data stands only in the cycle after the strobe, zero otherwise
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdata_q <= RPO_MAP_RST;
      end else if (reg_rd) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= RPO_MAP_RST;
      end
   end

   assign reg_rdata = rdata_q;

endmodule : rpo_pin_map

// ---- dv/rpo_pin_map_monitor.sv ----
// checker for the remappable output pin select block
`timescale 1ns/1ns
module rpo_pin_map_monitor
   import rpo_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [RPO_ADDR_W-1:0] reg_addr,
   input wire logic [RPO_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [RPO_DATA_W-1:0] reg_rdata,
   input wire logic [RPO_FUNC_W-1:0] periph_out,
   input wire logic [RPO_NUM_PINS-1:0] port_out,
   input wire logic [RPO_NUM_PINS-1:0] port_oe,
   input wire logic [RPO_NUM_PINS-1:0] remap_pin_out,
   input wire logic [RPO_NUM_PINS-1:0] remap_pin_oe
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // gap bits are not stored, so no read may show them
   gap_high_a: assert property (reg_rd |=> reg_rdata[15:14] == 2'b00)
      else $error("map bits 15:14 read nonzero");
   // status words fill bits 11:0, so bits 7:6 are a gap only in mapping reads
   gap_low_a: assert property (reg_rd && reg_addr <= 4'h5 |=> reg_rdata[7:6] == 2'b00)
      else $error("map bits 7:6 read nonzero");
   // reset wins even while it is held, hence no disable here
   rst_clear_a: assert property (disable iff (1'b0) rst |=>
      reg_rdata == 16'h0000 && remap_pin_oe == 12'h000 && remap_pin_out == 12'h000)
      else $error("outputs not cleared by reset");
   read_back_a: assert property (reg_wr && reg_addr < 4'h5 ##1
      reg_rd && reg_addr == $past(reg_addr) |=> reg_rdata == ($past(reg_wdata, 2) & 16'h3F3F))
      else $error("read after write lost the value");
   // read data stands one cycle only; unmapped offsets read zero
   rd_idle_a: assert property ((!reg_rd || reg_addr > 4'h8) |=> reg_rdata == 16'h0000)
      else $error("read data not zero");
   route_even_a: assert property (reg_wr && reg_addr == 4'h0 && reg_wdata[5:0] == 6'h03
      |=> ##1 remap_pin_oe[0] && remap_pin_out[0] == $past(periph_out[3]))
      else $error("pin 20 not routed to function 3");
   route_odd_a: assert property (reg_wr && reg_addr == 4'h0 && reg_wdata[13:8] == 6'h04
      |=> ##1 remap_pin_oe[1] && remap_pin_out[1] == $past(periph_out[4]))
      else $error("pin 21 not routed to function 4");
   no_route_a: assert property (reg_wr && reg_addr == 4'h0 &&
      (reg_wdata[5:0] == 6'h00 || reg_wdata[5]) |=> ##1
      remap_pin_oe[0] == $past(port_oe[0]) && remap_pin_out[0] == $past(port_out[0]))
      else $error("pin 20 not left to port control");
   // a port-driven pin never loses its drive, and an undriven pin keeps the port's level
   port_keep_a: assert property (((remap_pin_out ^ $past(port_out)) & ~remap_pin_oe) == 12'h000
      && (remap_pin_oe | $past(port_oe)) == remap_pin_oe)
      else $error("port drive lost");
endmodule : rpo_pin_map_monitor

bind rpo_pin_map rpo_pin_map_monitor i_rpo_pin_map_monitor (.sys_clk, .rst, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .periph_out, .port_out, .port_oe,
   .remap_pin_out, .remap_pin_oe);

// ---- dv/tb_top.sv ----
// self-checking bench for the remappable output pin select block
`timescale 1ns/1ns
module tb_top;
   import rpo_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [RPO_ADDR_W-1:0] reg_addr = 4'h0;
   logic [RPO_DATA_W-1:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [RPO_DATA_W-1:0] reg_rdata;
   logic [RPO_FUNC_W-1:0] periph_out = 64'h0;
   logic [RPO_NUM_PINS-1:0] port_out = 12'h000;
   logic [RPO_NUM_PINS-1:0] port_oe = 12'h000;
   logic [RPO_NUM_PINS-1:0] remap_pin_out;
   logic [RPO_NUM_PINS-1:0] remap_pin_oe;
   // outputs of the reduced pin count copy, which shares every input
   logic [RPO_DATA_W-1:0] red_rdata;
   logic [RPO_NUM_PINS-1:0] red_pin_out;
   logic [RPO_NUM_PINS-1:0] red_pin_oe;
   int mismatches = 0;
   int tests_run = 0;

   rpo_pin_map i_rpo_pin_map (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .periph_out, .port_out, .port_oe, .remap_pin_out, .remap_pin_oe);

   // reduced part without pin 31; sees the same bus traffic as the full part
   rpo_pin_map #(.FULL_PIN_COUNT(1'b0)) i_rpo_pin_map_reduced (.sys_clk, .rst, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata (red_rdata), .periph_out, .port_out, .port_oe,
      .remap_pin_out (red_pin_out), .remap_pin_oe (red_pin_oe));

   // 50 ns bus clock
   always #25 sys_clk = ~sys_clk;

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         mismatches++;
      end
   endtask : chk

   // also drops a pending write strobe, so a write may run straight into it
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      chk("read data", exp, reg_rdata);
   endtask : rd

   task automatic wr_rd(input logic [3:0] a, input logic [15:0] d, input logic [15:0] exp);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      rd(a, exp);
   endtask : wr_rd

   task automatic pads(input logic [1:0] oe, input logic [1:0] out);
      chk("pad oe", {14'h0, oe}, {14'h0, remap_pin_oe[1:0]});
      chk("pad out", {14'h0, out}, {14'h0, remap_pin_out[1:0]});
   endtask : pads

   task automatic t_reset();
      for (int k = 0; k < RPO_NUM_MAPS; k++) begin
         rd(4'(k), 16'h0000);
      end
      chk("all pad oe", 16'h0000, {4'h0, remap_pin_oe});
      $display("test reset done");
   endtask : t_reset

   // distinct data per register catches a shared or misdecoded register
   task automatic t_rw();
      for (int k = 0; k < RPO_NUM_MAPS; k++) begin
         wr_rd(4'(k), 16'hFFFF, 16'h3F3F);
         wr_rd(4'(k), 16'h2A10 | 16'(k), 16'h2A10 | 16'(k));
      end
      for (int k = 0; k < RPO_NUM_MAPS; k++) begin
         rd(4'(k), 16'h2A10 | 16'(k));
      end
      rd(4'hF, 16'h0000);
      $display("test read write done");
   endtask : t_rw

   task automatic t_route();
      @(posedge sys_clk);
      periph_out <= 64'h18;
      wr_rd(4'h0, 16'h0403, 16'h0403);
      pads(2'b11, 2'b11);
      @(posedge sys_clk);
      periph_out <= 64'h0;
      @(posedge sys_clk);
      @(negedge sys_clk);
      pads(2'b11, 2'b00);
      $display("test route done");
   endtask : t_route

   // last defined code routes, the first code above it does not
   task automatic t_undef();
      @(posedge sys_clk);
      periph_out <= 64'hFFFF_FFFF_FFFF_FFFF;
      // port drive differs from what a wrongly routed pin would show
      port_out <= 12'h001;
      port_oe <= 12'h002;
      wr_rd(4'h0, 16'h201F, 16'h201F);
      pads(2'b11, 2'b01);
      // even pins hold defined codes, odd pins undefined ones; pins 22 to 31 still hold those of the read write test
      rd(RPO_OFF_ROUTE_STAT, 16'h0555);
      rd(RPO_OFF_BAD_SEL, 16'h0AAA);
      rd(RPO_OFF_PAD_LEVEL, 16'h0555);
      wr_rd(4'h0, 16'h0020, 16'h0020);
      pads(2'b10, 2'b01);
      $display("test undefined done");
   endtask : t_undef

   // the reduced part drops the pin 31 field on write and leaves pin 31 to its port
   task automatic t_reduced();
      wr_rd(RPO_OFF_MAP_30_31, 16'h0507, 16'h0507);
      chk("reduced map 30 31", 16'h0007, red_rdata);
      chk("reduced pin31 oe", 16'h0000, {15'h0, red_pin_oe[11]});
      chk("reduced pin31 out", 16'h0000, {15'h0, red_pin_out[11]});
      chk("full pin31 oe", 16'h0001, {15'h0, remap_pin_oe[11]});
      chk("full pin31 out", 16'h0001, {15'h0, remap_pin_out[11]});
      $display("test reduced part done");
   endtask : t_reduced

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : tally_and_finish

   // the tests need some 90 cycles; far beyond that means a hang
   initial begin
      #(3000 * 50);
      mismatches++;
      tally_and_finish();
   end

   initial begin
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset();
      t_rw();
      t_route();
      t_undef();
      t_reduced();
      tally_and_finish();
   end
endmodule : tb_top
